// ---- verilog/ctp_pkg.sv ----
// How it works
// - Trigger acts on edges in manual modes, on its level otherwise
// - Trigger works only when enable bit set
// - Manual modes: rising edge starts one capture
// - Streaming/auto spectrum: high keeps conversion running
// - Trigger low: finish record, then halt
// - Streaming: busy low while buffers load
// - Streaming: busy high when frame ready
// - Other modes: busy refuses serial access
// - Command done: release port, busy high
// - While busy only escape code aborts capture
// - Alarm outputs follow alarm control settings
// - Alarm outputs unused in streaming mode
// - Over-temperature shutdown drives supply monitor low
// - Reset restores known state, reloads parameters
// - Data output driven only while select low
package ctp_pkg;
  // ----------------------------------------
  // Capture modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    CTP_MODE_MANUAL_TIME = 2'h0,
    CTP_MODE_MANUAL_SPEC = 2'h1,
    CTP_MODE_AUTO_SPEC = 2'h2,
    CTP_MODE_STREAM = 2'h3
  } ctp_mode_t;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [15:0] CTP_CMD_CAPTURE = 16'h0800;
  localparam logic [15:0] CTP_CMD_ESCAPE = 16'h00E8;
  localparam int CTP_TRIG_EN_BIT = 12;
  localparam int CTP_ALARM_CTRL_W = 4;
  // Alarm control field positions: enable and polarity per output
  localparam int CTP_ALARM_ONE_EN_POS = 0;
  localparam int CTP_ALARM_ONE_POL_POS = 1;
  localparam int CTP_ALARM_TWO_EN_POS = 2;
  localparam int CTP_ALARM_TWO_POL_POS = 3;
  // Reset value of the parameter load counter
  localparam logic [3:0] CTP_LOAD_RST = 4'h0;
endpackage

// ---- verilog/ctp_trig_if.sv ----
`timescale 1ns/1ps
// Carries the qualified trigger events from the detector to the core
interface ctp_trig_if;
  logic rise; // Qualified rising edge pulse
  logic level; // Qualified trigger level
  modport src (output rise, output level);
  modport dst (input rise, input level);
endinterface

// ---- verilog/ctp_trig_det.sv ----
`timescale 1ns/1ps
// Edge detector for the external trigger pin
module ctp_trig_det
  import ctp_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_trig,
  input wire logic i_trig_en,
  ctp_trig_if.src trig
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic prev; // Last sampled pin level
    logic rise; // Registered rising edge
  } ctp_det_t;

  ctp_det_t st_ff;
  ctp_det_t nxt_st;

  // Next state: only a transition produces an event
  always_comb begin
    nxt_st = st_ff;
    nxt_st.prev = i_trig;
    nxt_st.rise = i_trig_en & i_trig & ~st_ff.prev;
  end

  // Register
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign trig.rise = st_ff.rise;
  assign trig.level = i_trig_en & st_ff.prev;
endmodule

// ---- verilog/ctp_core.sv ----
`timescale 1ns/1ps
// Trigger, busy, alarm and supply monitor pin control
module ctp_core
  import ctp_pkg::*;
#(
  parameter int LOAD_CYCLES = 8 // Cycles spent reloading stored parameters
)
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_trig,
  input wire logic [15:0] i_misc_ctrl,
  input wire logic [1:0] i_mode,
  input wire logic i_cmd_valid,
  input wire logic [15:0] i_cmd_data,
  input wire logic i_exec_done,
  input wire logic i_buf_loading,
  input wire logic i_frame_ready,
  input wire logic i_record_done,
  input wire logic [CTP_ALARM_CTRL_W-1:0] i_alarm_ctrl,
  input wire logic i_alarm_one_event,
  input wire logic i_alarm_two_event,
  input wire logic i_over_temp,
  input wire logic i_cs_n,
  input wire logic i_dout_data,
  output logic o_busy,
  output logic o_spi_allow,
  output logic o_capture_start,
  output logic o_abort,
  output logic o_convert,
  output logic o_param_load,
  output logic o_alarm_output_one,
  output logic o_alarm_output_two,
  output logic o_supply_monitor_output,
  output logic o_dout,
  output logic o_dout_oe
);
  // ----------------------------------------
  // Trigger detector
  // ----------------------------------------
  // Pin edge and level, already qualified by the enable bit
  ctp_trig_if trig ();

  ctp_trig_det u_det (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_trig(i_trig),
    .i_trig_en(i_misc_ctrl[CTP_TRIG_EN_BIT]),
    .trig(trig)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  // One-hot control states; any other code falls back to a reload
  typedef enum logic [3:0] {
    ST_LOAD = 4'b0001, // Reloading stored parameters
    ST_IDLE = 4'b0010, // Port free
    ST_EXEC = 4'b0100, // Command or capture running
    ST_RUN = 4'b1000 // Continuous conversion
  } ctp_state_t;

  // All core registers in one word, reset together; cleared except state to ST_LOAD and vddm high
  typedef struct packed {
    ctp_state_t state;
    logic [3:0] load_cnt; // Parameter load counter
    logic stopping; // Finishing last record
    logic busy; // Busy pin level
    logic start; // Capture start pulse
    logic abort; // Abort pulse
    logic alarm_one; // Alarm output one
    logic alarm_two; // Alarm output two
    logic vddm; // Supply monitor level
    logic dout; // Registered data out
  } ctp_core_t;

  ctp_core_t st_ff;
  ctp_core_t nxt_st;

  // Mode decode shared by the next-state logic and the outputs
  logic stream_mode; // Streaming selected
  logic cont_mode; // Level-gated modes
  logic manual_go; // Capture requested in manual modes
  logic [3:0] load_last; // Final load count

  // Streaming and automatic spectrum are gated by the trigger level;
  // the manual modes take a command or a qualified edge instead
  assign stream_mode = (ctp_mode_t'(i_mode) == CTP_MODE_STREAM);
  assign cont_mode = stream_mode | (ctp_mode_t'(i_mode) == CTP_MODE_AUTO_SPEC);
  assign manual_go = (i_cmd_valid & (i_cmd_data == CTP_CMD_CAPTURE)) | trig.rise;
  assign load_last = 4'(LOAD_CYCLES - 1);

  // Alarm pin drive from enable and polarity fields
  function automatic logic alm_drive(input logic ev, input logic en, input logic pol);
    alm_drive = en & (ev ^ pol);
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // Start and abort pulses last a single cycle
    nxt_st.start = 1'b0;
    nxt_st.abort = 1'b0;
    case (st_ff.state)
      ST_LOAD: begin
        // Hold busy until stored parameters are back
        nxt_st.busy = 1'b0;
        if (st_ff.load_cnt == load_last) begin
          nxt_st.state = ST_IDLE;
          nxt_st.busy = 1'b1;
        end else begin
          nxt_st.load_cnt = st_ff.load_cnt + 4'h1;
        end
      end
      ST_IDLE: begin
        // Port free; wait for a capture request
        nxt_st.busy = 1'b1;
        if (cont_mode) begin
          // Level-gated modes: edges and capture commands start nothing here
          if (trig.level) begin
            nxt_st.state = ST_RUN;
            nxt_st.stopping = 1'b0;
            // Auto spectrum is busy while running; streaming has no frame yet
            nxt_st.busy = 1'b0;
          end
        end else if (manual_go) begin
          // Manual modes: one record per request
          nxt_st.state = ST_EXEC;
          nxt_st.start = 1'b1;
          nxt_st.busy = 1'b0;
        end
      end
      ST_EXEC: begin
        // Busy; only the escape code is honoured
        // A second capture request is dropped while this one runs
        if (i_cmd_valid & (i_cmd_data == CTP_CMD_ESCAPE)) begin
          nxt_st.abort = 1'b1;
          nxt_st.state = ST_IDLE;
          nxt_st.busy = 1'b1;
        end else if (i_exec_done) begin
          nxt_st.state = ST_IDLE;
          nxt_st.busy = 1'b1;
        end
      end
      ST_RUN: begin
        // Keep converting while the trigger is high
        if (!trig.level) begin
          nxt_st.stopping = 1'b1;
        end
        // Stop only at a record boundary, so the last record is whole
        if ((st_ff.stopping | ~trig.level) & i_record_done) begin
          nxt_st.state = ST_IDLE;
          nxt_st.stopping = 1'b0;
        end
        // Streaming: the busy pin doubles as data ready
        if (stream_mode) begin
          if (i_buf_loading) begin
            nxt_st.busy = 1'b0;
          end else if (i_frame_ready) begin
            nxt_st.busy = 1'b1;
          end
        end else begin
          // Auto spectrum: port closed until the run ends
          nxt_st.busy = 1'b0;
        end
      end
      default: begin
        // Unknown state code: recover through a reload
        nxt_st.state = ST_LOAD;
      end
    endcase
    // Alarm pins idle in streaming mode
    if (stream_mode) begin
      nxt_st.alarm_one = 1'b0;
      nxt_st.alarm_two = 1'b0;
    end else begin
      nxt_st.alarm_one = alm_drive(i_alarm_one_event, i_alarm_ctrl[CTP_ALARM_ONE_EN_POS],
                                   i_alarm_ctrl[CTP_ALARM_ONE_POL_POS]);
      nxt_st.alarm_two = alm_drive(i_alarm_two_event, i_alarm_ctrl[CTP_ALARM_TWO_EN_POS],
                                   i_alarm_ctrl[CTP_ALARM_TWO_POL_POS]);
    end
    // Monitor pin is low only during thermal shutdown
    nxt_st.vddm = ~i_over_temp;
    // Data bit is registered; the enable below decides if it reaches the pin
    nxt_st.dout = i_dout_data;
  end

  // ----------------------------------------
  // Register
  // ----------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_ff <= '0;
      st_ff.state <= ST_LOAD;
      st_ff.load_cnt <= CTP_LOAD_RST;
      // Monitor idles high, so reset never looks like a shutdown
      st_ff.vddm <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_busy = st_ff.busy;
  // Serial port is open when ready, or at any time while streaming runs
  assign o_spi_allow = st_ff.busy | (st_ff.state == ST_RUN && stream_mode);
  assign o_capture_start = st_ff.start;
  assign o_abort = st_ff.abort;
  // Handshake outputs decode the state directly
  assign o_convert = (st_ff.state == ST_RUN);
  assign o_param_load = (st_ff.state == ST_LOAD);
  assign o_alarm_output_one = st_ff.alarm_one;
  assign o_alarm_output_two = st_ff.alarm_two;
  assign o_supply_monitor_output = st_ff.vddm;
  assign o_dout = st_ff.dout;
  // Enable follows chip select alone, so the data pin floats when deselected
  assign o_dout_oe = ~i_cs_n;
endmodule

// ---- bench/ctp_host_model.sv ----
`timescale 1ns/1ps
// Host side of the trigger pin: pulses on request, or holds a level
module ctp_host_model (
  input wire logic i_core_clk,
  input wire logic i_busy,
  input wire logic i_fire,
  input wire logic i_level,
  output logic o_trig
);
  logic [1:0] pulse_ff = 2'h0; // Remaining high cycles of a pulse
  // A pulse is only started while the device reports ready
  always_ff @(posedge i_core_clk) begin
    if (i_fire && i_busy) begin
      pulse_ff <= 2'h3;
    end else if (pulse_ff != 2'h0) begin
      pulse_ff <= pulse_ff - 2'h1;
    end
  end
  assign o_trig = i_level | (pulse_ff != 2'h0);
endmodule

// ---- bench/ctp_core_chk.sv ----
`timescale 1ns/1ps
// Port checker for the pin control core
module ctp_core_chk
  import ctp_pkg::*;
#(parameter int LOAD_CYCLES = 8)
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_trig,
  input wire logic [15:0] i_misc_ctrl,
  input wire logic [1:0] i_mode,
  input wire logic i_cmd_valid,
  input wire logic [15:0] i_cmd_data,
  input wire logic i_exec_done,
  input wire logic [CTP_ALARM_CTRL_W-1:0] i_alarm_ctrl,
  input wire logic i_alarm_one_event,
  input wire logic i_alarm_two_event,
  input wire logic i_over_temp,
  input wire logic i_cs_n,
  input wire logic o_busy,
  input wire logic o_capture_start,
  input wire logic o_abort,
  input wire logic o_convert,
  input wire logic o_param_load,
  input wire logic o_alarm_output_one,
  input wire logic o_alarm_output_two,
  input wire logic o_supply_monitor_output,
  input wire logic o_dout_oe
);
  localparam int LD_MAX = LOAD_CYCLES + 3; // Reload bound with margin
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire logic en = i_misc_ctrl[CTP_TRIG_EN_BIT]; // Trigger enable
  wire logic idle_man = o_busy && !i_mode[1]; // Ready in a manual mode
  wire logic busy_man = !o_busy && !o_param_load && !i_mode[1];
  AST_CMD_START: assert property (idle_man && i_cmd_valid &&
    i_cmd_data == CTP_CMD_CAPTURE |=> o_capture_start && !o_busy) else $error("no start");
  AST_TRIG_START: assert property (idle_man && en && $rose(i_trig) &&
    !i_cmd_valid && !i_exec_done |-> ##[1:2] o_capture_start) else $error("no trig start");
  AST_TRIG_OFF: assert property ((!en && !i_cmd_valid)[*3]
    |=> !o_capture_start) else $error("disabled trigger started");
  AST_ESCAPE: assert property (busy_man && i_cmd_valid &&
    i_cmd_data == CTP_CMD_ESCAPE |=> o_abort && o_busy) else $error("escape lost");
  AST_DONE: assert property (busy_man && i_exec_done |=> o_busy)
    else $error("busy not released");
  AST_ALM_STREAM: assert property (i_mode == CTP_MODE_STREAM |=>
    !o_alarm_output_one && !o_alarm_output_two) else $error("alarm in streaming");
  AST_ALM_FOLLOW: assert property (i_mode != CTP_MODE_STREAM && i_alarm_ctrl == 4'h5
    |=> o_alarm_output_one == $past(i_alarm_one_event) &&
    o_alarm_output_two == $past(i_alarm_two_event))
    else $error("alarm mismatch");
  AST_VDDM: assert property (1'b1 |=> o_supply_monitor_output == !$past(i_over_temp))
    else $error("supply monitor mismatch");
  AST_OE: assert property (o_dout_oe == !i_cs_n) else $error("data enable wrong");
  AST_LOAD: assert property ($fell(i_rst) |-> o_param_load ##[1:LD_MAX] o_busy)
    else $error("reload not done");
  cover property (o_capture_start);
  cover property (o_abort);
  cover property (o_convert ##1 !o_convert);
endmodule
bind ctp_core ctp_core_chk #(.LOAD_CYCLES(LOAD_CYCLES)) i_ctp_core_chk (.*);

// ---- bench/tb_capture_trigger_busy_pins.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module tb_capture_trigger_busy_pins;
  import ctp_pkg::*;
  logic i_core_clk = 0, i_rst = 1, i_trig, i_cmd_valid = 0, i_exec_done = 0, i_buf_loading = 0;
  logic i_frame_ready = 0, i_record_done = 0, i_alarm_one_event = 0, i_alarm_two_event = 0;
  logic i_over_temp = 0, i_cs_n = 1, i_dout_data = 0, fire = 0, lvl = 0;
  logic [15:0] i_misc_ctrl = '0, i_cmd_data = '0;
  logic [1:0] i_mode = '0;
  logic [3:0] i_alarm_ctrl = 4'h5;
  logic o_busy, o_spi_allow, o_capture_start, o_abort, o_convert, o_param_load;
  logic o_alarm_output_one, o_alarm_output_two, o_supply_monitor_output, o_dout, o_dout_oe;
  int fail_count = 0, cmp_count = 0, cyc = 0, n;
  logic [7:0] rnd = 8'h54; // Random source state
  logic [3:0] ac; // Random alarm control word
  logic [3:0] q[$]; // Expected alarm, monitor and data outputs
  ctp_core #(.LOAD_CYCLES(2)) i_ctp_core (.*);
  ctp_host_model i_ctp_host_model (.i_core_clk, .i_busy(o_busy), .i_fire(fire),
    .i_level(lvl), .o_trig(i_trig));
  function automatic logic [7:0] lf(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task nx(input int k); repeat (k) @(posedge i_core_clk); endtask
  task cmd(input logic [15:0] d);
    nx(1); i_cmd_valid <= 1; i_cmd_data <= d; nx(1); i_cmd_valid <= 0; #1;
  endtask
  task done; nx(1); i_exec_done <= 1; nx(1); i_exec_done <= 0; #1; endtask
  task results;
    $display("mismatches %0d of %0d checks", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial forever #10 i_core_clk = ~i_core_clk;
  // Cut a hang short
  always @(posedge i_core_clk) if (++cyc == 3000) begin fail_count++; results(); end
  initial begin
    nx(12); i_rst <= 0; #1;
    `CHK(o_param_load, 1'b1)
    for (n = 0; n < 20 && o_busy !== 1'b1; n++) begin nx(1); #1; end
    `CHK(o_busy, 1'b1)
    // Manual modes: command, refusal, escape, trigger
    for (int m = 0; m < 2; m++) begin
      nx(1); i_mode <= m[1:0];
      cmd(CTP_CMD_CAPTURE); `CHK({o_capture_start, o_busy}, 2'h2)
      cmd(CTP_CMD_CAPTURE); `CHK({o_capture_start, o_busy}, 2'h0)
      cmd(CTP_CMD_ESCAPE); `CHK({o_abort, o_busy}, 2'h3)
      cmd(CTP_CMD_CAPTURE); done(); `CHK(o_busy, 1'b1)
      for (int e = 0; e < 2; e++) begin
        nx(1); i_misc_ctrl[CTP_TRIG_EN_BIT] <= e[0]; fire <= 1; nx(1); fire <= 0; n = 0;
        repeat (8) begin nx(1); #1 n += o_capture_start; end
        `CHK(n, e)
        done();
      end
    end
    // Continuous modes follow the trigger level
    for (int m = 2; m < 4; m++) begin
      nx(1); i_mode <= m[1:0]; lvl <= 1; nx(4);
      #1 `CHK({o_convert, o_busy, o_spi_allow}, {2'b10, m[0]})
      if (m == 3) begin
        i_frame_ready <= 1; nx(2); #1 `CHK(o_busy, 1'b1)
        i_frame_ready <= 0; i_buf_loading <= 1; nx(2); #1 `CHK(o_busy, 1'b0)
        i_buf_loading <= 0;
      end
      lvl <= 0; nx(3); #1 `CHK(o_convert, 1'b1)
      i_record_done <= 1; nx(1); i_record_done <= 0; nx(2); #1 `CHK(o_convert, 1'b0)
    end
    // Random alarm, monitor and data traffic against the queue model
    for (n = 0; n < 40; n++) begin
      nx(1); rnd = lf(rnd); ac = rnd[3:0]; rnd = lf(rnd);
      {i_alarm_one_event, i_alarm_two_event, i_dout_data, i_cs_n} <= rnd[3:0];
      i_over_temp <= &rnd[6:4]; i_mode <= {2{rnd[7]}}; i_alarm_ctrl <= ac;
      #1 if (q.size() > 0) `CHK({o_alarm_output_one, o_alarm_output_two,
        o_supply_monitor_output, o_dout}, q.pop_front())
      `CHK(o_dout_oe, ~rnd[0])
      q.push_back({ac[0] & (rnd[3] ^ ac[1]) & ~rnd[7], ac[2] & (rnd[2] ^ ac[3]) & ~rnd[7],
        ~&rnd[6:4], rnd[1]});
    end
    results();
  end
endmodule
